/* File: src/sfp_pkg.sv */
package sfp_pkg;

  localparam int             ADDR_W           = 20;
  localparam int             PAGE_BYTES       = 256;
  localparam int             SECTORS          = 16;
  localparam int             SECTOR_LSB       = 16;
  localparam int             CLK_PERIOD_NS    = 50;

  localparam logic [7:0]     OP_PROGRAM       = 8'h02;
  localparam logic [7:0]     OP_ERASE_4K      = 8'h20;
  localparam logic [7:0]     OP_ERASE_32K     = 8'h52;
  localparam logic [7:0]     OP_ERASE_64K     = 8'hD8;
  localparam logic [7:0]     OP_CHIP_ERASE_A  = 8'h60;
  localparam logic [7:0]     OP_CHIP_ERASE_B  = 8'hC7;
  localparam logic [7:0]     OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0]     OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0]     OP_NONE          = 8'h00;

  localparam logic [7:0]     ERASED_BYTE      = 8'hFF;
  localparam logic [2:0]     FULL_HEADER      = 3'h4;
  localparam logic [2:0]     LAST_BIT         = 3'h7;
  localparam logic [19:0]    MASK_4K          = 20'h00FFF;
  localparam logic [19:0]    MASK_32K         = 20'h07FFF;
  localparam logic [19:0]    MASK_64K         = 20'h0FFFF;
  localparam logic [19:0]    MASK_CHIP        = 20'hFFFFF;

  // Defaults only; the real times are per-part figures
  localparam int             PAGE_PROGRAM_TIME_NS = 1000000;
  localparam int             BLOCK_ERASE_TIME_NS  = 50000000;
  localparam int             CHIP_ERASE_TIME_NS   = 400000000;

  typedef enum logic [1:0] {
    ER_4K,
    ER_32K,
    ER_64K,
    ER_CHIP
  } sfp_erase_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PROG,
    ST_WAIT,
    ST_VERIFY,
    ST_CHECK
  } sfp_state_t;

  function automatic logic [19:0] sfp_region_mask(input sfp_erase_t kind);
    case (kind)
      ER_4K:   return MASK_4K;
      ER_32K:  return MASK_32K;
      ER_64K:  return MASK_64K;
      default: return MASK_CHIP;
    endcase
  endfunction

endpackage

/* File: src/sfp_page_buf.sv */
`timescale 1ns/1ps
module sfp_page_buf
  import sfp_pkg::*;
#(
  parameter int DEPTH = PAGE_BYTES,
  parameter int WIDTH = 8
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     clr,
  input  wire logic                     wr,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [WIDTH-1:0]         rd_data,
  output logic                          rd_valid
);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("sfp_page_buf: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] valid_r;

  // Later bytes overwrite the same slot, so only the last DEPTH survive
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid_r <= '0;
    end else begin
      if (clr) begin
        valid_r <= '0;
      end
      if (wr) begin
        valid_r[wr_idx] <= 1'b1;
      end
    end
  end

  assign rd_data  = mem[rd_idx];
  assign rd_valid = valid_r[rd_idx];

endmodule

/* File: src/sfp_sequencer.sv */
`timescale 1ns/1ps
module sfp_sequencer
  import sfp_pkg::*;
#(
  parameter int PAGE_PROGRAM_NS = PAGE_PROGRAM_TIME_NS,
  parameter int BLOCK_ERASE_NS  = BLOCK_ERASE_TIME_NS,
  parameter int CHIP_ERASE_NS   = CHIP_ERASE_TIME_NS
) (
  input  wire logic                CLOCK,
  input  wire logic                RSTN,
  input  wire logic                CS_N,
  input  wire logic                SCK,
  input  wire logic                SI,
  input  wire logic [SECTORS-1:0]  SECT_PROT,
  input  wire logic [7:0]          ARR_RDATA,
  output logic      [ADDR_W-1:0]   ARR_ADDR,
  output logic      [7:0]          ARR_WDATA,
  output logic                     ARR_WR,
  output logic                     ARR_RD,
  output logic                     ARR_ERASE,
  output sfp_erase_t               ARR_ERASE_KIND,
  output logic                     BUSY,
  output logic                     WRITE_ENABLE_LATCH,
  output logic                     PROGRAM_ERASE_ERROR_FLAG
);

  function automatic logic [31:0] ns_to_cycles(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return 32'(c);
  endfunction

  localparam logic [31:0] PAGE_PROGRAM_CYC = ns_to_cycles(PAGE_PROGRAM_NS);
  localparam logic [31:0] BLOCK_ERASE_CYC  = ns_to_cycles(BLOCK_ERASE_NS);
  localparam logic [31:0] CHIP_ERASE_CYC   = ns_to_cycles(CHIP_ERASE_NS);

  if (PAGE_PROGRAM_NS < 1 || BLOCK_ERASE_NS < 1 || CHIP_ERASE_NS < 1) begin : g_bad_time
    $error("sfp_sequencer: operation times must be positive");
  end

  // Serial front end
  logic              sck_prev_r;
  logic              cs_n_prev_r;
  logic              frame_live_r;
  logic [2:0]        bit_cnt_r;
  logic [6:0]        shift_r;
  logic [2:0]        byte_cnt_r;
  logic [7:0]        opcode_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        data_idx_r;
  logic              have_data_r;

  // Operation engine
  sfp_state_t        state_r;
  logic [ADDR_W-1:0] cur_r;
  logic [ADDR_W-1:0] last_r;
  logic              is_erase_r;
  logic [31:0]       timer_r;

  logic              sck_rise;
  logic              frame_start;
  logic              frame_end;
  logic              idle;
  logic              byte_done;
  logic [7:0]        rx_byte;
  logic              aligned;
  logic              addr_done;
  logic              prot_sel;
  logic              buf_wr;
  logic [7:0]        buf_wr_idx;
  logic [7:0]        buf_rd_data;
  logic              buf_rd_valid;
  logic [7:0]        expected;

  logic              start_prog;
  logic              start_erase;
  logic              wel_set;
  logic              wel_clr;
  sfp_erase_t        erase_kind_nxt;

  assign idle        = (state_r == ST_IDLE);
  assign sck_rise    = SCK & ~sck_prev_r & ~CS_N;
  assign frame_start = cs_n_prev_r & ~CS_N;
  assign frame_end   = ~cs_n_prev_r & CS_N;
  assign byte_done   = sck_rise & frame_live_r & (bit_cnt_r == LAST_BIT);
  assign rx_byte     = {shift_r, SI};
  assign aligned     = (bit_cnt_r == 3'h0);
  assign addr_done   = (byte_cnt_r == FULL_HEADER);
  assign prot_sel    = SECT_PROT[addr_r[ADDR_W-1:SECTOR_LSB]];
  assign buf_wr      = byte_done & addr_done & (opcode_r == OP_PROGRAM);
  assign buf_wr_idx  = addr_r[7:0] + data_idx_r;
  assign expected    = is_erase_r ? ERASED_BYTE : buf_rd_data;

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      sck_prev_r  <= 1'b0;
      cs_n_prev_r <= 1'b1;
    end else begin
      sck_prev_r  <= SCK;
      cs_n_prev_r <= CS_N;
    end
  end

  // Frames that open while an operation runs are ignored whole
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      frame_live_r <= 1'b0;
    end else if (frame_start) begin
      frame_live_r <= idle;
    end else if (frame_end) begin
      frame_live_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      bit_cnt_r   <= 3'h0;
      shift_r     <= 7'h00;
      byte_cnt_r  <= 3'h0;
      opcode_r    <= OP_NONE;
      addr_r      <= '0;
      data_idx_r  <= 8'h00;
      have_data_r <= 1'b0;
    end else if (frame_start) begin
      bit_cnt_r   <= 3'h0;
      byte_cnt_r  <= 3'h0;
      opcode_r    <= OP_NONE;
      data_idx_r  <= 8'h00;
      have_data_r <= 1'b0;
    end else if (sck_rise && frame_live_r) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r   <= {shift_r[5:0], SI};
      if (bit_cnt_r == LAST_BIT) begin
        if (!addr_done) begin
          byte_cnt_r <= byte_cnt_r + 3'h1;
        end
        if (byte_cnt_r == 3'h0) begin
          opcode_r <= rx_byte;
        end else if (!addr_done) begin
          addr_r <= {addr_r[ADDR_W-9:0], rx_byte};
        end else if (opcode_r == OP_PROGRAM) begin
          data_idx_r  <= data_idx_r + 8'h01;
          have_data_r <= 1'b1;
        end
      end
    end
  end

  // Decide what a closed frame asks for
  always_comb begin
    start_prog     = 1'b0;
    start_erase    = 1'b0;
    wel_set        = 1'b0;
    wel_clr        = 1'b0;
    erase_kind_nxt = ER_4K;
    if (frame_end && frame_live_r) begin
      case (opcode_r)
        OP_WRITE_ENABLE: begin
          wel_set = aligned;
        end
        OP_WRITE_DISABLE: begin
          wel_clr = aligned;
        end
        OP_PROGRAM: begin
          if (WRITE_ENABLE_LATCH) begin
            if (addr_done && have_data_r && aligned && !prot_sel) begin
              start_prog = 1'b1;
            end else begin
              wel_clr = 1'b1;
            end
          end
        end
        OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K: begin
          if (opcode_r == OP_ERASE_32K) begin
            erase_kind_nxt = ER_32K;
          end else if (opcode_r == OP_ERASE_64K) begin
            erase_kind_nxt = ER_64K;
          end
          if (WRITE_ENABLE_LATCH) begin
            if (addr_done && aligned && !prot_sel) begin
              start_erase = 1'b1;
            end else if (!addr_done || prot_sel) begin
              wel_clr = 1'b1;
            end
          end
        end
        OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
          erase_kind_nxt = ER_CHIP;
          if (WRITE_ENABLE_LATCH && aligned) begin
            if (|SECT_PROT) begin
              wel_clr = 1'b1;
            end else begin
              start_erase = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      WRITE_ENABLE_LATCH <= 1'b0;
    end else if (wel_set) begin
      WRITE_ENABLE_LATCH <= 1'b1;
    end else if (wel_clr || start_prog || start_erase) begin
      WRITE_ENABLE_LATCH <= 1'b0;
    end
  end

  sfp_page_buf #(
    .DEPTH (PAGE_BYTES),
    .WIDTH (8)
  ) u_buf (
    .clk      (CLOCK),
    .rst_n    (RSTN),
    .clr      (frame_start & idle),
    .wr       (buf_wr),
    .wr_idx   (buf_wr_idx),
    .wr_data  (rx_byte),
    .rd_idx   (cur_r[7:0]),
    .rd_data  (buf_rd_data),
    .rd_valid (buf_rd_valid)
  );

  // Write pass for a program only, timed wait, then read-back pass over the touched bytes
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      state_r                  <= ST_IDLE;
      cur_r                    <= '0;
      last_r                   <= '0;
      is_erase_r               <= 1'b0;
      timer_r                  <= 32'h0000_0000;
      BUSY                     <= 1'b0;
      PROGRAM_ERASE_ERROR_FLAG <= 1'b0;
      ARR_ADDR                 <= '0;
      ARR_WDATA                <= 8'h00;
      ARR_WR                   <= 1'b0;
      ARR_RD                   <= 1'b0;
      ARR_ERASE                <= 1'b0;
      ARR_ERASE_KIND           <= ER_4K;
    end else begin
      ARR_WR    <= 1'b0;
      ARR_RD    <= 1'b0;
      ARR_ERASE <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_prog) begin
            cur_r                    <= {addr_r[ADDR_W-1:8], 8'h00};
            last_r                   <= {addr_r[ADDR_W-1:8], 8'hFF};
            is_erase_r               <= 1'b0;
            BUSY                     <= 1'b1;
            PROGRAM_ERASE_ERROR_FLAG <= 1'b0;
            state_r                  <= ST_PROG;
          end else if (start_erase) begin
            cur_r                    <= addr_r & ~sfp_region_mask(erase_kind_nxt);
            last_r                   <= addr_r | sfp_region_mask(erase_kind_nxt);
            is_erase_r               <= 1'b1;
            timer_r                  <= (erase_kind_nxt == ER_CHIP) ? CHIP_ERASE_CYC
                                                                     : BLOCK_ERASE_CYC;
            ARR_ERASE                <= 1'b1;
            ARR_ERASE_KIND           <= erase_kind_nxt;
            ARR_ADDR                 <= addr_r & ~sfp_region_mask(erase_kind_nxt);
            BUSY                     <= 1'b1;
            PROGRAM_ERASE_ERROR_FLAG <= 1'b0;
            state_r                  <= ST_WAIT;
          end
        end
        ST_PROG: begin
          if (buf_rd_valid) begin
            ARR_WR    <= 1'b1;
            ARR_ADDR  <= cur_r;
            ARR_WDATA <= buf_rd_data;
          end
          if (cur_r == last_r) begin
            cur_r   <= {cur_r[ADDR_W-1:8], 8'h00};
            timer_r <= PAGE_PROGRAM_CYC;
            state_r <= ST_WAIT;
          end else begin
            cur_r <= cur_r + 20'h00001;
          end
        end
        ST_WAIT: begin
          timer_r <= timer_r - 32'h0000_0001;
          if (timer_r == 32'h0000_0001) begin
            state_r <= ST_VERIFY;
          end
        end
        ST_VERIFY: begin
          if (is_erase_r || buf_rd_valid) begin
            ARR_RD   <= 1'b1;
            ARR_ADDR <= cur_r;
            state_r  <= ST_CHECK;
          end else if (cur_r == last_r) begin
            BUSY    <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            cur_r <= cur_r + 20'h00001;
          end
        end
        ST_CHECK: begin
          if (ARR_RDATA != expected) begin
            PROGRAM_ERASE_ERROR_FLAG <= 1'b1;
          end
          if (cur_r == last_r) begin
            BUSY    <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            cur_r   <= cur_r + 20'h00001;
            state_r <= ST_VERIFY;
          end
        end
        default: begin
          BUSY    <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: verification/sfp_sequencer_sva.sv */
`timescale 1ns/1ps
module sfp_sequencer_sva
  import sfp_pkg::*;
(
  input wire logic         CLOCK,
  input wire logic         RSTN,
  input wire logic         CS_N,
  input wire logic         SCK,
  input wire logic         SI,
  input wire logic [15:0]  SECT_PROT,
  input wire logic [7:0]   ARR_RDATA,
  input wire logic [19:0]  ARR_ADDR,
  input wire logic [7:0]   ARR_WDATA,
  input wire logic         ARR_WR,
  input wire logic         ARR_RD,
  input wire logic         ARR_ERASE,
  input wire sfp_erase_t   ARR_ERASE_KIND,
  input wire logic         BUSY,
  input wire logic         WRITE_ENABLE_LATCH,
  input wire logic         PROGRAM_ERASE_ERROR_FLAG
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  sequence op_start;
    $rose(BUSY);
  endsequence

  sequence frame_closed;
    $past(CS_N) && !$past(CS_N, 2);
  endsequence

  sequence verify_pair;
    ARR_RD ##1 !ARR_RD;
  endsequence

  AST_START_AFTER_FRAME: assert property (op_start |-> frame_closed)
    else $error("operation began without a closed frame");
  AST_START_NEEDS_LATCH: assert property (op_start |-> $past(WRITE_ENABLE_LATCH))
    else $error("operation began with the latch clear");
  AST_LATCH_LOW_BUSY: assert property (BUSY |-> !WRITE_ENABLE_LATCH)
    else $error("latch high while busy");
  AST_QUIET_IDLE: assert property (!BUSY |-> !ARR_WR && !ARR_RD && !ARR_ERASE)
    else $error("array strobe while idle");
  AST_ERASE_FIRST: assert property (ARR_ERASE |-> op_start)
    else $error("erase strobe not at operation start");
  AST_ERASE_BASE: assert property (ARR_ERASE |->
    (ARR_ERASE_KIND == ER_4K && ARR_ADDR[11:0] == 12'h000) ||
    (ARR_ERASE_KIND == ER_32K && ARR_ADDR[14:0] == 15'h0000) ||
    (ARR_ERASE_KIND == ER_64K && ARR_ADDR[15:0] == 16'h0000) ||
    (ARR_ERASE_KIND == ER_CHIP && ARR_ADDR == 20'h00000))
    else $error("erase base not aligned to region");
  AST_ERASE_SINGLE: assert property (ARR_ERASE |=> (!ARR_ERASE && !ARR_WR) [*8])
    else $error("erase strobe repeated");
  AST_VERIFY_PAIR: assert property (ARR_RD |-> verify_pair ##0 !ARR_WR)
    else $error("verify read not a single pulse");
  AST_BUSY_FALL: assert property ($fell(BUSY) |->
    !$past(ARR_WR) && !$past(ARR_WR, 2) && !$past(ARR_ERASE) && !$past(ARR_ERASE, 2))
    else $error("busy fell during the write pass");
  AST_ERR_STEADY: assert property (!BUSY && !$past(BUSY) |->
    $stable(PROGRAM_ERASE_ERROR_FLAG))
    else $error("error flag moved while idle");
endmodule

/* File: verification/sfp_host_model.sv */
`timescale 1ns/1ps
module sfp_host_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  initial begin
    cs_n = 1'h1;
    sck = 1'h0;
    si = 1'h0;
  end

  // Cut drops trailing bits: whole bytes, or enough to end off a byte boundary
  // Idle is the resting level of sck: low for mode 0, high for mode 3
  task automatic frame(input logic [7:0] q[$], input int cut, input logic idle);
    int n;
    n = q.size() * 8 - cut;
    @(posedge clk) sck <= idle;
    @(posedge clk) cs_n <= 1'h0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) si <= q[i / 8][7 - i % 8];
      sck <= 1'h0;
      @(posedge clk) sck <= 1'h1;
    end
    @(posedge clk) sck <= idle;
    @(posedge clk) cs_n <= 1'h1;
    si <= ~si;
  endtask
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import sfp_pkg::*;
;
  logic        CLOCK;
  logic        RSTN;
  wire         CS_N;
  wire         SCK;
  wire         SI;
  logic [15:0] SECT_PROT;
  logic [7:0]  ARR_RDATA;
  logic [19:0] ARR_ADDR;
  logic [7:0]  ARR_WDATA;
  logic        ARR_WR;
  logic        ARR_RD;
  logic        ARR_ERASE;
  sfp_erase_t  ARR_ERASE_KIND;
  logic        BUSY;
  logic        WRITE_ENABLE_LATCH;
  logic        PROGRAM_ERASE_ERROR_FLAG;
  logic [7:0]  mem [0:1048575];
  logic [7:0]  exp_wr [int];
  logic [19:0] exp_base;
  sfp_erase_t  exp_kind;
  logic        exp_er;
  int          msk;
  int          stuck;
  int          seed;
  int          fails;
  int          comparisons;
  logic        sck_idle;

  sfp_sequencer #(.PAGE_PROGRAM_NS(500), .BLOCK_ERASE_NS(500), .CHIP_ERASE_NS(500))
  sfp_sequencer_inst (.CLOCK, .RSTN, .CS_N, .SCK, .SI, .SECT_PROT, .ARR_RDATA,
    .ARR_ADDR, .ARR_WDATA, .ARR_WR, .ARR_RD, .ARR_ERASE, .ARR_ERASE_KIND, .BUSY,
    .WRITE_ENABLE_LATCH, .PROGRAM_ERASE_ERROR_FLAG);
  sfp_host_model sfp_host_model_inst (.clk(CLOCK), .cs_n(CS_N), .sck(SCK), .si(SI));

  assign ARR_RDATA = ARR_RD ? mem[ARR_ADDR] : 8'h5A;

  initial begin
    CLOCK = 1'h0;
    forever #25 CLOCK = ~CLOCK;
  end

  task automatic chk_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_word(input string n, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic final_report;
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Array model: programming only clears bits, erase sets a region to FF but forces the stuck byte to 00
  always @(posedge CLOCK) begin
    if (ARR_WR) begin
      chk_bit("write_addr", 1'h1, exp_wr.exists(int'(ARR_ADDR)));
      if (exp_wr.exists(int'(ARR_ADDR))) begin
        chk_word("write_data", {12'h000, exp_wr[int'(ARR_ADDR)]}, {12'h000, ARR_WDATA});
        exp_wr.delete(int'(ARR_ADDR));
      end
      mem[ARR_ADDR] = mem[ARR_ADDR] & ARR_WDATA;
    end
    if (ARR_ERASE) begin
      chk_bit("erase_wanted", 1'h1, exp_er);
      chk_word("erase_base", exp_base, ARR_ADDR);
      chk_word("erase_kind", {18'h00000, exp_kind}, {18'h00000, ARR_ERASE_KIND});
      exp_er = 1'h0;
      msk = ARR_ERASE_KIND == ER_4K ? 'hFFF : ARR_ERASE_KIND == ER_32K ? 'h7FFF :
            ARR_ERASE_KIND == ER_64K ? 'hFFFF : 'hFFFFF;
      for (int a = int'(ARR_ADDR); a <= (int'(ARR_ADDR) | msk); a++) begin
        mem[a] = (a == stuck) ? 8'h00 : 8'hFF;
      end
    end
  end

  task automatic op(input logic [7:0] q[$], input int cut, input logic act,
                    input logic write_enable_latch, input logic err, input logic poke);
    int k;
    sfp_host_model_inst.frame(q, cut, sck_idle);
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
    chk_bit("busy", act, BUSY);
    if (poke) sfp_host_model_inst.frame('{OP_WRITE_ENABLE}, 0, sck_idle);
    k = 0;
    while (BUSY !== 1'h0 && k < 90000) begin
      @(negedge CLOCK);
      k++;
    end
    chk_bit("busy_end", 1'h0, BUSY);
    chk_bit("latch", write_enable_latch, WRITE_ENABLE_LATCH);
    if (act) chk_bit("error", err, PROGRAM_ERASE_ERROR_FLAG);
    chk_bit("writes_done", 1'h1, exp_wr.size() == 0);
    chk_bit("erase_done", 1'h0, exp_er);
  endtask

  task automatic wen(input logic [7:0] opc);
    op('{opc}, 0, 1'h0, opc == OP_WRITE_ENABLE, 1'h0, 1'h0);
  endtask

  task automatic pgm(input logic [23:0] a, input int n, input int cut, input logic act);
    logic [7:0] q[$];
    logic [7:0] d;
    logic       err;
    q = '{OP_PROGRAM, a[23:16], a[15:8], a[7:0]};
    err = 1'h0;
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      q.push_back(d);
      if (act) exp_wr[{a[19:8], 8'(a[7:0] + i)}] = d;
    end
    foreach (exp_wr[k]) if ((mem[k] & exp_wr[k]) !== exp_wr[k]) err = 1'h1;
    op(q, cut, act, 1'h0, err, 1'h0);
  endtask

  task automatic ers(input logic [7:0] opc, input logic [23:0] a, input int cut,
                     input logic act, input logic write_enable_latch, input sfp_erase_t kind);
    int m;
    m = kind == ER_4K ? 'hFFF : kind == ER_32K ? 'h7FFF : kind == ER_64K ? 'hFFFF : 'hFFFFF;
    exp_er = act;
    exp_kind = kind;
    exp_base = a[19:0] & ~20'(m);
    op('{opc, a[23:16], a[15:8], a[7:0], 8'h3C}, cut, act, write_enable_latch,
       stuck >= int'(exp_base) && stuck <= (int'(exp_base) | m), act);
  endtask

  task automatic prot(input logic [15:0] v);
    @(posedge CLOCK) SECT_PROT <= v;
  endtask

  initial begin
    seed = 69;
    stuck = -1;
    fails = 0;
    comparisons = 0;
    exp_er = 1'h0;
    exp_base = 20'h00000;
    exp_kind = ER_4K;
    sck_idle = 1'h0;
    RSTN = 1'h0;
    SECT_PROT = 16'h0000;
    for (int a = 0; a < 1048576; a++) mem[a] = 8'hFF;
    repeat (3) @(posedge CLOCK);
    RSTN <= 1'h1;
    @(negedge CLOCK);
    chk_bit("reset_latch", 1'h0, WRITE_ENABLE_LATCH);
    wen(OP_WRITE_ENABLE);
    pgm(24'hF000FE, 3, 0, 1'h1);
    wen(OP_WRITE_ENABLE);
    pgm(24'h012310, 260, 0, 1'h1);
    pgm(24'h020000, 2, 0, 1'h0);
    wen(OP_WRITE_ENABLE);
    wen(OP_WRITE_DISABLE);
    pgm(24'h020000, 2, 0, 1'h0);
    wen(OP_WRITE_ENABLE);
    pgm(24'h020000, 2, 3, 1'h0);
    wen(OP_WRITE_ENABLE);
    pgm(24'h020000, 0, 0, 1'h0);
    wen(OP_WRITE_ENABLE);
    pgm(24'h020000, 1, 16, 1'h0);
    prot(16'h0004);
    wen(OP_WRITE_ENABLE);
    pgm(24'h020000, 1, 0, 1'h0);
    wen(OP_WRITE_ENABLE);
    ers(OP_ERASE_4K, 24'h021234, 8, 1'h0, 1'h0, ER_4K);
    wen(OP_WRITE_ENABLE);
    ers(OP_CHIP_ERASE_A, 24'h000000, 32, 1'h0, 1'h0, ER_CHIP);
    wen(OP_WRITE_ENABLE);
    ers(OP_CHIP_ERASE_B, 24'h000000, 24, 1'h0, 1'h0, ER_CHIP);
    sck_idle = 1'h1;
    prot(16'h0000);
    wen(OP_WRITE_ENABLE);
    ers(OP_CHIP_ERASE_B, 24'h000000, 28, 1'h0, 1'h1, ER_CHIP);
    for (int a = 'h45610; a < 'h45614; a++) mem[a] = 8'h00;
    pgm(24'h045610, 4, 0, 1'h1);
    wen(OP_WRITE_ENABLE);
    ers(OP_ERASE_4K, 24'h034567, 0, 1'h1, 1'h0, ER_4K);
    stuck = 'h0B123;
    wen(OP_WRITE_ENABLE);
    ers(OP_ERASE_32K, 24'h00ABCD, 8, 1'h1, 1'h0, ER_32K);
    wen(OP_WRITE_ENABLE);
    ers(OP_ERASE_64K, 24'h050000, 4, 1'h0, 1'h1, ER_64K);
    ers(OP_ERASE_64K, 24'h050000, 16, 1'h0, 1'h0, ER_64K);
    final_report();
  end

  initial begin
    repeat (100000) @(posedge CLOCK);
    fails++;
    final_report();
  end
endmodule

bind sfp_sequencer sfp_sequencer_sva sfp_sequencer_sva_inst (.CLOCK, .RSTN, .CS_N, .SCK,
  .SI, .SECT_PROT, .ARR_RDATA, .ARR_ADDR, .ARR_WDATA, .ARR_WR, .ARR_RD, .ARR_ERASE,
  .ARR_ERASE_KIND, .BUSY, .WRITE_ENABLE_LATCH, .PROGRAM_ERASE_ERROR_FLAG);
